// File: rtl/rcd_crc16.sv
// byte-serial crc16 engine, one bit per clock
`timescale 1ns/1ns
module rcd_crc16 (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control
    input wire logic i_clear,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    // result
    output logic o_busy,
    output logic [15:0] o_crc
);
    logic [15:0] crc_reg;
    logic [3:0] step_reg;
    logic [15:0] shifted;

    assign o_busy = (step_reg != 4'h0);
    assign o_crc = crc_reg;
    always_comb begin
        shifted = {1'b0, crc_reg[15:1]};
        if (crc_reg[0]) begin
            shifted = shifted ^ rcd_pkg::CRC_POLY;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b || i_clear) begin
            crc_reg <= rcd_pkg::CRC_PRESET;
            step_reg <= 4'h0;
        end else if (step_reg != 4'h0) begin
            crc_reg <= shifted;
            step_reg <= step_reg - 4'h1;
        end else if (i_byte_valid) begin
            crc_reg <= crc_reg ^ {8'h00, i_byte};
            step_reg <= rcd_pkg::CRC_STEPS;
        end
    end

    eight_steps_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_byte_valid && !o_busy && !i_clear) |=> o_busy [*8] ##1 !o_busy)
        else $error("crc step count wrong");
endmodule : rcd_crc16

// File: rtl/rcd_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module rcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign o_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_valid = (count_reg != '0);
    assign o_data = mem[rd_reg];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : rcd_fifo

// File: rtl/rcd_frame.sv
// rtu request checker, address decoder and reply builder
`timescale 1ns/1ns
// Operation
// - every frame ends in a two-byte crc computed over all bytes before it.
// - the received crc is recomputed and compared; a mismatch is a transmission error.
// - the crc accumulator starts at all ones for each frame.
// - only the eight data bits of each character enter the crc.
// - each byte is xored into the low accumulator byte before its bit steps.
// - each bit step shifts the accumulator right with a zero entering the top.
// - if the bit shifted out was one the result is xored with the reflected polynomial.
// - eight bit steps are done per byte before the next byte.
// - after the last byte the accumulator holds the frame's crc.
// - a parameter group-index maps to group in the high byte and index in the low byte.
// - parameter addresses accept groups 00 to 0f and any index byte.
// - address bit 15 set makes a write go to the volatile copy only; reads work normally.
// - the control command word is read/write and decodes codes 1 to 7; 8 is reserved. Reads here return the parameter store word, not the command register.
// - frames are delimited by at least 3.5 character times of silence.
// - function 03 reads up to 12 consecutive words and 06 writes a single word.
module rcd_frame (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // received characters, data bits only, from the uart
    input wire logic [7:0] i_station,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_frame_gap,
    // reply characters to the uart
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    input wire logic i_tx_ready,
    // parameter store port
    output logic o_par_req,
    output logic o_par_write,
    output logic o_par_volatile,
    output logic [15:0] o_par_addr,
    output logic [15:0] o_par_wdata,
    input wire logic [15:0] i_par_rdata,
    // drive command decode
    output logic [15:0] o_ctrl_cmd,
    output logic o_cmd_fwd_run,
    output logic o_cmd_rev_run,
    output logic o_cmd_fwd_jog,
    output logic o_cmd_rev_jog,
    output logic o_cmd_stop,
    output logic o_cmd_coast,
    output logic o_cmd_fault_rst,
    output logic o_crc_error
);
    typedef enum logic [2:0] {
        ST_RECV = 3'b000,
        ST_CHECK = 3'b001,
        ST_EXEC = 3'b010,
        ST_WORD = 3'b011,
        ST_CRC = 3'b100,
        ST_DROP = 3'b101
    } rcd_state_type;

    rcd_state_type state_reg;
    logic [7:0] req_reg [8];
    logic [7:0] len_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] addr_reg;
    logic [15:0] left_reg;
    logic [1:0] crc_ph_reg;
    logic crc_err_reg;
    logic crc_clear;
    logic crc_feed;
    logic [7:0] crc_byte;
    logic crc_busy;
    logic [15:0] crc_val;
    logic q_valid;
    logic [7:0] q_byte;
    logic q_ready;
    logic [15:0] req_addr;
    logic [15:0] req_data;
    logic [14:0] plain_addr;
    logic addr_ok;
    logic is_ctrl;
    logic [7:0] func;
    logic cmd_pulse;

    assign func = req_reg[1];
    assign req_addr = {req_reg[2], req_reg[3]};
    assign req_data = {req_reg[4], req_reg[5]};
    assign plain_addr = req_addr[14:0];
    assign is_ctrl = (req_addr == rcd_pkg::CTRL_CMD_ADDR);
    assign addr_ok = is_ctrl || (plain_addr[14:8] <= 7'(rcd_pkg::GROUP_MAX));

    rcd_crc16 u_crc (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_clear(crc_clear),
        .i_byte_valid(crc_feed),
        .i_byte(crc_byte),
        .o_busy(crc_busy),
        .o_crc(crc_val)
    );

    rcd_fifo #(.WIDTH(rcd_pkg::BYTE_W), .DEPTH(rcd_pkg::FIFO_DEPTH)) u_txq (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_valid(q_valid),
        .i_data(q_byte),
        .o_ready(q_ready),
        .o_valid(o_tx_valid),
        .o_data(o_tx_byte),
        .i_ready(i_tx_ready)
    );

    // crc feed: received bytes before the crc pair while receiving, reply bytes before the crc pair while sending
    // a good frame's gap keeps the sum for the check; restart after the check and after the reply
    assign crc_clear = (state_reg == ST_RECV && i_frame_gap && len_reg != rcd_pkg::REQ_LEN)
        || (state_reg == ST_CHECK && !crc_busy)
        || (state_reg == ST_CRC && q_valid && q_ready && crc_ph_reg[0]);
    always_comb begin
        crc_feed = 1'b0;
        crc_byte = 8'h00;
        if (state_reg == ST_RECV && i_rx_valid && len_reg < rcd_pkg::REQ_LEN - 8'h2) begin
            crc_feed = 1'b1;
            crc_byte = i_rx_byte;
        end else if (q_valid && q_ready && state_reg != ST_CRC) begin
            crc_feed = 1'b1;
            crc_byte = q_byte;
        end
    end

    // reply byte source; queue fill stalls on crc busy and queue full
    always_comb begin
        q_valid = 1'b0;
        q_byte = 8'h00;
        if (!crc_busy) begin
            unique case (state_reg)
                ST_EXEC: begin
                    // header bytes may be zero; only a broadcast stays silent
                    q_valid = (req_reg[0] != rcd_pkg::BCAST_ADDR);
                    q_byte = left_reg[7:0];
                end
                ST_WORD: begin
                    q_valid = 1'b1;
                    q_byte = left_reg[7:0];
                end
                ST_CRC: begin
                    q_valid = 1'b1;
                    q_byte = crc_ph_reg[0] ? crc_val[15:8] : crc_val[7:0];
                end
                default: begin
                    q_valid = 1'b0;
                end
            endcase
        end
    end

    // left_reg doubles as an opcode/byte shuttle: in exec, low byte is next header byte
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= ST_RECV;
            len_reg <= 8'h00;
            addr_reg <= 16'h0000;
            left_reg <= 16'h0000;
            crc_ph_reg <= 2'h0;
            crc_err_reg <= 1'b0;
            for (int k = 0; k < 8; k++) begin
                req_reg[k] <= 8'h00;
            end
        end else begin
            crc_err_reg <= 1'b0;
            unique case (state_reg)
                ST_RECV: begin
                    if (i_frame_gap) begin
                        len_reg <= 8'h00;
                        if (len_reg == rcd_pkg::REQ_LEN) begin
                            state_reg <= ST_CHECK;
                        end
                    end else if (i_rx_valid && len_reg < rcd_pkg::REQ_LEN) begin
                        req_reg[len_reg[2:0]] <= i_rx_byte;
                        len_reg <= len_reg + 8'h1;
                    end else if (i_rx_valid) begin
                        len_reg <= 8'hff;
                    end
                end
                ST_CHECK: begin
                    if (!crc_busy) begin
                        if (crc_val != {req_reg[7], req_reg[6]}) begin
                            crc_err_reg <= 1'b1;
                            state_reg <= ST_RECV;
                        end else if (req_reg[0] != i_station && req_reg[0] != rcd_pkg::BCAST_ADDR) begin
                            state_reg <= ST_RECV;
                        end else begin
                            state_reg <= ST_EXEC;
                            addr_reg <= req_addr;
                            left_reg <= {8'h00, req_reg[0]};
                            crc_ph_reg <= 2'h0;
                        end
                    end
                end
                ST_EXEC: begin
                    if (req_reg[0] == rcd_pkg::BCAST_ADDR) begin
                        state_reg <= ST_RECV;
                    end else if (q_valid && q_ready) begin
                        crc_ph_reg <= crc_ph_reg + 2'h1;
                        if (func == rcd_pkg::FC_WRITE && addr_ok) begin
                            // echo header: station, func, addr hi/lo, data hi/lo
                            unique case (crc_ph_reg)
                                2'h0: left_reg <= {8'h00, func};
                                2'h1: left_reg <= {8'h00, req_reg[2]};
                                2'h2: left_reg <= {8'h00, req_reg[3]};
                                default: left_reg <= {8'h00, req_reg[4]};
                            endcase
                            if (crc_ph_reg == 2'h3) begin
                                state_reg <= ST_WORD;
                                left_reg <= {8'h01, req_reg[4]};
                            end
                        end else if (func == rcd_pkg::FC_READ && addr_ok
                                     && req_data != 16'h0 && req_data <= rcd_pkg::READ_MAX_WORDS) begin
                            unique case (crc_ph_reg)
                                2'h0: left_reg <= {8'h00, func};
                                default: left_reg <= {8'h00, req_data[6:0], 1'b0};
                            endcase
                            if (crc_ph_reg == 2'h2) begin
                                state_reg <= ST_WORD;
                                left_reg <= {req_data[7:0], i_par_rdata[15:8]};
                                crc_ph_reg <= 2'h0;
                            end
                        end else begin
                            unique case (crc_ph_reg)
                                2'h0: left_reg <= {8'h00, func | rcd_pkg::EXC_FLAG};
                                default: left_reg <= {8'h00, (func != rcd_pkg::FC_READ && func != rcd_pkg::FC_WRITE)
                                    ? rcd_pkg::EXC_FUNC : (addr_ok ? rcd_pkg::EXC_COUNT : rcd_pkg::EXC_ADDR)};
                            endcase
                            if (crc_ph_reg == 2'h2) begin
                                state_reg <= ST_CRC;
                                crc_ph_reg <= 2'h0;
                            end
                        end
                    end
                end
                ST_WORD: begin
                    if (q_valid && q_ready) begin
                        if (func == rcd_pkg::FC_WRITE) begin
                            left_reg <= {8'h00, req_reg[5]};
                            if (left_reg[15:8] == 8'h00) begin
                                state_reg <= ST_CRC;
                                crc_ph_reg <= 2'h0;
                            end
                        end else if (crc_ph_reg[0] == 1'b0) begin
                            left_reg <= {left_reg[15:8], i_par_rdata[7:0]};
                            crc_ph_reg <= 2'h1;
                        end else if (left_reg[15:8] == 8'h01) begin
                            state_reg <= ST_CRC;
                            crc_ph_reg <= 2'h0;
                        end else begin
                            addr_reg <= addr_reg + 16'h1;
                            left_reg <= {left_reg[15:8] - 8'h1, 8'h00};
                            crc_ph_reg <= 2'h2;
                        end
                    end
                end
                ST_CRC: begin
                    if (q_valid && q_ready) begin
                        crc_ph_reg <= crc_ph_reg + 2'h1;
                        if (crc_ph_reg[0]) begin
                            state_reg <= ST_RECV;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RECV;
                end
            endcase
            if (state_reg == ST_WORD && crc_ph_reg == 2'h2) begin
                left_reg <= {left_reg[15:8], i_par_rdata[15:8]};
                crc_ph_reg <= 2'h0;
            end
        end
    end

    // parameter store access; bit 15 selects the ram-only copy
    assign o_par_addr = (state_reg == ST_WORD) ? addr_reg : req_addr;
    assign o_par_volatile = o_par_addr[rcd_pkg::ALIAS_BIT];
    assign o_par_wdata = req_data;
    assign cmd_pulse = (state_reg == ST_EXEC) && (crc_ph_reg == 2'h0) && (req_reg[0] == rcd_pkg::BCAST_ADDR || q_valid
        && q_ready) && func == rcd_pkg::FC_WRITE && addr_ok;
    assign o_par_write = cmd_pulse && !is_ctrl;
    assign o_par_req = o_par_write || (state_reg == ST_WORD && func == rcd_pkg::FC_READ)
        || (state_reg == ST_EXEC && func == rcd_pkg::FC_READ);
    assign o_crc_error = crc_err_reg;

    // control command word: stored on write, reads come back through the store path
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ctrl_reg <= rcd_pkg::CTRL_CMD_RESET;
        end else if (cmd_pulse && is_ctrl) begin
            ctrl_reg <= req_data;
        end
    end
    assign o_ctrl_cmd = ctrl_reg;
    // code 8 and above decode to nothing
    assign o_cmd_fwd_run = ctrl_reg == {13'h0, rcd_pkg::CMD_FWD_RUN};
    assign o_cmd_rev_run = ctrl_reg == {13'h0, rcd_pkg::CMD_REV_RUN};
    assign o_cmd_fwd_jog = ctrl_reg == {13'h0, rcd_pkg::CMD_FWD_JOG};
    assign o_cmd_rev_jog = ctrl_reg == {13'h0, rcd_pkg::CMD_REV_JOG};
    assign o_cmd_stop = ctrl_reg == {13'h0, rcd_pkg::CMD_STOP};
    assign o_cmd_coast = ctrl_reg == {13'h0, rcd_pkg::CMD_COAST};
    assign o_cmd_fault_rst = ctrl_reg == {13'h0, rcd_pkg::CMD_FAULT_RST};

    bad_crc_drop_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_crc_error |-> state_reg == ST_RECV && !o_par_write)
        else $error("bad crc frame not dropped");
    ctrl_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (cmd_pulse && is_ctrl) |=> o_ctrl_cmd == $past(req_data))
        else $error("control word not stored");
    alias_ram_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_par_write |-> o_par_volatile == req_addr[15])
        else $error("alias bit not honoured");
    group_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_par_write |-> req_addr[14:8] <= 7'h0f)
        else $error("group out of range written");
    crc_low_first_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_CRC && q_valid && q_ready && !crc_ph_reg[0]) |-> q_byte == crc_val[7:0])
        else $error("crc low byte not first");
    crc_preset_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        crc_clear |=> crc_val == 16'hffff)
        else $error("crc not preset");
    no_bcast_reply_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_EXEC && req_reg[0] == 8'h00) |=> state_reg == ST_RECV)
        else $error("broadcast answered");
    check_wait_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        state_reg == ST_CHECK |-> ##[1:9] state_reg != ST_CHECK)
        else $error("crc check stuck");
endmodule : rcd_frame

// File: rtl/rcd_pkg.sv
// shared constants for the rtu frame checker and address decoder
package rcd_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [3:0] CRC_STEPS = 4'h8;
    localparam logic [15:0] CTRL_CMD_ADDR = 16'h1000;
    localparam logic [15:0] CTRL_CMD_RESET = 16'h0000;
    localparam logic [7:0] GROUP_MAX = 8'h0f;
    localparam int ALIAS_BIT = 15;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [15:0] READ_MAX_WORDS = 16'h000c;
    localparam logic [7:0] REQ_LEN = 8'h08;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_COUNT = 8'h03;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [2:0] CMD_FWD_RUN = 3'h1;
    localparam logic [2:0] CMD_REV_RUN = 3'h2;
    localparam logic [2:0] CMD_FWD_JOG = 3'h3;
    localparam logic [2:0] CMD_REV_JOG = 3'h4;
    localparam logic [2:0] CMD_STOP = 3'h5;
    localparam logic [2:0] CMD_COAST = 3'h6;
    localparam logic [2:0] CMD_FAULT_RST = 3'h7;
endpackage : rcd_pkg

// File: tb/rcd_frame_test.sv
// self-checking bench for the rtu frame checker
`timescale 1ns/1ns
module rcd_frame_test;
    localparam logic [7:0] STN = 8'h11;
    logic i_clock = 1'b0;
    logic rst_b = 1'b0;
    logic go = 1'b0;
    logic [63:0] frame = 64'h0;
    logic stall = 1'b0;
    logic hold_stall = 1'b0;
    logic [7:0] dst = STN;
    logic busy, rx_valid, gap, tx_valid, tx_ready, par_req, par_write, par_vol, crc_err, w_vol;
    logic [7:0] rx_byte, tx_byte;
    logic [15:0] par_addr, par_wdata, ctrl, w_addr, w_data, a, d;
    logic [6:0] cmd;
    logic [15:0] seed = 16'h0017;
    logic [7:0] rxq[$];
    logic [7:0] exp[$];
    int err_total = 0;
    int n_tests = 0;
    int w_cnt = 0;
    int e_cnt = 0;
    int e0;
    int k;
    always #20 i_clock = ~i_clock;
    rcd_master_model u_master (.i_clock(i_clock), .i_rst_b(rst_b), .i_go(go), .i_frame(frame),
        .i_stall(stall), .o_busy(busy), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
        .o_frame_gap(gap), .o_tx_ready(tx_ready));
    rcd_frame DUT (.i_clock(i_clock), .i_rst_b(rst_b), .i_station(STN), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .i_frame_gap(gap), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
        .i_tx_ready(tx_ready), .o_par_req(par_req), .o_par_write(par_write), .o_par_volatile(par_vol),
        .o_par_addr(par_addr), .o_par_wdata(par_wdata), .i_par_rdata(par_addr ^ 16'h5a5a),
        .o_ctrl_cmd(ctrl), .o_cmd_fwd_run(cmd[0]), .o_cmd_rev_run(cmd[1]), .o_cmd_fwd_jog(cmd[2]),
        .o_cmd_rev_jog(cmd[3]), .o_cmd_stop(cmd[4]), .o_cmd_coast(cmd[5]), .o_cmd_fault_rst(cmd[6]),
        .o_crc_error(crc_err));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = rcd_pkg::CRC_PRESET;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ rcd_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc16
    always @(posedge i_clock) begin
        seed <= lfsr(seed);
        stall <= hold_stall | seed[0];
        if (tx_valid && tx_ready)
            rxq.push_back(tx_byte);
        if (par_write) begin
            w_cnt++;
            w_addr <= par_addr;
            w_data <= par_wdata;
            w_vol <= par_vol;
        end
        if (crc_err)
            e_cnt++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic add_crc(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask : add_crc
    task automatic send(input logic [7:0] fc, input logic [15:0] sa, input logic [15:0] sd, input logic [7:0] bad);
        logic [7:0] q[$];
        q = '{dst, fc, sa[15:8], sa[7:0], sd[15:8], sd[7:0]};
        add_crc(q);
        q[6] = q[6] ^ bad;
        rxq.delete();
        @(posedge i_clock);
        frame <= {q[0], q[1], q[2], q[3], q[4], q[5], q[6], q[7]};
        go <= 1'b1;
        @(posedge i_clock);
        go <= 1'b0;
        // the model loads on this edge, so busy shows one edge later
        @(posedge i_clock);
        for (k = 0; busy === 1'b1 && k < 200; k++)
            @(posedge i_clock);
        if (k >= 200) begin
            err_total++;
            finish_test();
        end
    endtask : send
    task automatic expect_reply();
        for (k = 0; rxq.size() < exp.size() && k < 3000; k++)
            @(posedge i_clock);
        repeat (60) @(posedge i_clock);
        chk(16'(rxq.size()), 16'(exp.size()));
        for (int i = 0; i < exp.size() && i < rxq.size(); i++)
            chk({8'h00, rxq[i]}, {8'h00, exp[i]});
        if (k >= 3000) begin
            err_total++;
            finish_test();
        end
    endtask : expect_reply
    task automatic echo(input logic [7:0] fc, input logic [15:0] ea, input logic [15:0] ed);
        exp = '{STN, fc, ea[15:8], ea[7:0], ed[15:8], ed[7:0]};
        add_crc(exp);
    endtask : echo
    task automatic exc(input logic [7:0] fc, input logic [7:0] code);
        exp = '{STN, fc | rcd_pkg::EXC_FLAG, code};
        add_crc(exp);
    endtask : exc
    task automatic rd(input logic [15:0] ra, input int n);
        logic [15:0] v;
        exp = '{STN, rcd_pkg::FC_READ, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
            v = (ra + 16'(i)) ^ 16'h5a5a;
            exp.push_back(v[15:8]);
            exp.push_back(v[7:0]);
        end
        add_crc(exp);
    endtask : rd
    initial begin
        repeat (8) @(posedge i_clock);
        rst_b <= 1'b1;
        @(posedge i_clock);
        chk(ctrl, rcd_pkg::CTRL_CMD_RESET);
        chk({7'h00, tx_valid, crc_err, cmd}, 16'h0000);
        // every command code, then the reserved one
        for (int c = 1; c <= 8; c++) begin
            echo(rcd_pkg::FC_WRITE, rcd_pkg::CTRL_CMD_ADDR, 16'(c));
            send(rcd_pkg::FC_WRITE, rcd_pkg::CTRL_CMD_ADDR, 16'(c), 8'h00);
            expect_reply();
            chk(ctrl, 16'(c));
            chk({9'h000, cmd}, (c < 8) ? (16'h0001 << (c - 1)) : 16'h0000);
        end
        chk(16'(w_cnt), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 16'h8006 : (i == 1) ? 16'h050a : (i == 2) ? 16'h0fff : {seed[15], 3'h0, seed[11:0]};
            d = lfsr(seed);
            echo(rcd_pkg::FC_WRITE, a, d);
            send(rcd_pkg::FC_WRITE, a, d, 8'h00);
            expect_reply();
            chk(16'(w_cnt), 16'(i + 1));
            chk(w_addr, a);
            chk(w_data, d);
            chk({15'h0, w_vol}, {15'h0, a[15]});
        end
        // stalled consumer lets the reply fill the fifo
        hold_stall <= 1'b1;
        rd(16'h0500, 12);
        send(rcd_pkg::FC_READ, 16'h0500, 16'h000c, 8'h00);
        repeat (400) @(posedge i_clock);
        chk({15'h0, tx_valid}, 16'h0001);
        chk(16'(rxq.size()), 16'h0000);
        hold_stall <= 1'b0;
        expect_reply();
        rd(16'h8006, 1);
        send(rcd_pkg::FC_READ, 16'h8006, 16'h0001, 8'h00);
        expect_reply();
        exc(rcd_pkg::FC_READ, rcd_pkg::EXC_ADDR);
        send(rcd_pkg::FC_READ, 16'h1100, 16'h0001, 8'h00);
        expect_reply();
        exc(rcd_pkg::FC_READ, rcd_pkg::EXC_COUNT);
        send(rcd_pkg::FC_READ, 16'h0500, 16'h000d, 8'h00);
        expect_reply();
        send(rcd_pkg::FC_READ, 16'h0500, 16'h0000, 8'h00);
        expect_reply();
        exc(8'h10, rcd_pkg::EXC_FUNC);
        send(8'h10, 16'h0500, 16'h0001, 8'h00);
        expect_reply();
        e0 = e_cnt;
        exp.delete();
        send(rcd_pkg::FC_WRITE, rcd_pkg::CTRL_CMD_ADDR, 16'h0006, 8'h01);
        expect_reply();
        chk(16'(e_cnt), 16'(e0 + 1));
        chk(ctrl, 16'h0008);
        chk(16'(w_cnt), 16'h0008);
        // broadcast runs silently, another station's request is ignored
        dst = rcd_pkg::BCAST_ADDR;
        send(rcd_pkg::FC_WRITE, rcd_pkg::CTRL_CMD_ADDR, 16'h0005, 8'h00);
        expect_reply();
        chk(ctrl, 16'h0005);
        dst = 8'h22;
        send(rcd_pkg::FC_WRITE, rcd_pkg::CTRL_CMD_ADDR, 16'h0007, 8'h00);
        expect_reply();
        chk(ctrl, 16'h0005);
        finish_test();
    end
endmodule : rcd_frame_test

// File: tb/rcd_master_model.sv
// bus master model: sends request frames, drains replies
`timescale 1ns/1ns
module rcd_master_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // requests from the bench
    input wire logic i_go,
    input wire logic [63:0] i_frame,
    input wire logic i_stall,
    output logic o_busy,
    // link to the slave
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_frame_gap,
    output logic o_tx_ready
);
    logic [63:0] sh_reg;
    logic [7:0] cnt_reg;
    assign o_busy = (cnt_reg != 8'h00);
    assign o_tx_ready = !i_stall;
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cnt_reg <= 8'h00;
            sh_reg <= 64'h0;
            o_rx_valid <= 1'b0;
            o_frame_gap <= 1'b0;
            o_rx_byte <= 8'h00;
        end else begin
            o_rx_valid <= 1'b0;
            o_frame_gap <= (cnt_reg == 8'h01);
            // idle data line toggles so stale bytes never look valid
            o_rx_byte <= ~o_rx_byte;
            if (i_go && cnt_reg == 8'h00) begin
                // one byte every 16 clocks: the slave's crc needs 9 clocks per byte
                cnt_reg <= 8'h81;
                sh_reg <= i_frame;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg[3:0] == 4'h1 && cnt_reg > 8'h01) begin
                    o_rx_valid <= 1'b1;
                    o_rx_byte <= sh_reg[63:56];
                    sh_reg <= {sh_reg[55:0], 8'h00};
                end
            end
        end
    end
endmodule : rcd_master_model
